// ===== logic/evpu_pkg.sv
// Package for the exception vector and priority unit
package evpu_pkg;
    localparam int          NUM_VEC    = 40;
    localparam logic [5:0]  VEC_RESET  = 6'h00;
    localparam logic [5:0]  VEC_NMI    = 6'h07;
    localparam logic [5:0]  VEC_TRAP0  = 6'h08;
    localparam logic [5:0]  VEC_SLEEP  = 6'h0D;
    localparam logic [5:0]  VEC_WDT    = 6'h1F;
    localparam logic [5:0]  VEC_AEC    = 6'h20;
    localparam logic [5:0]  VEC_SERIAL = 6'h22;
    localparam logic [5:0]  VEC_TIMW   = 6'h23;
    // Request line positions, indexed by vector number
    localparam logic [NUM_VEC-1:0] VALID_MASK = 40'h6F_FFE7_0080;
    localparam logic [NUM_VEC-1:0] MASKABLE   = 40'h6F_FFE7_0000;
    localparam logic        MASK_RESET = 1'b1;
    typedef enum logic [2:0] {
        EVPU_RESET, EVPU_FETCH_HI, EVPU_FETCH_LO, EVPU_FIRST, EVPU_RUN
    } evpu_state_e;
endpackage : evpu_pkg

// ===== logic/evpu_prio_enc.sv
// Fixed priority encoder: lowest valid vector number wins
`timescale 1ns/1ps
module evpu_prio_enc
(
    // Pending request vector
    input  wire logic [evpu_pkg::NUM_VEC-1:0] i_req,
    // Winner
    output logic                              o_any,
    output logic [5:0]                        o_vec
);
    import evpu_pkg::*;

    // Scan from high to low so the smallest index is kept last
    always_comb
    begin
        o_any = 1'b0;
        o_vec = 6'h00;
        for (int k = NUM_VEC - 1; k >= 0; k--)
        begin
            if (i_req[k])
            begin
                o_any = 1'b1;
                o_vec = 6'(k);
            end
        end
    end
endmodule : evpu_prio_enc

// ===== logic/evpu_top.sv
// Exception arbitration and vector fetch sequencer
`timescale 1ns/1ps
module evpu_top
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // Reset sources
    input  wire logic        i_wdt_reset_ovf,
    // CPU sequencer side
    input  wire logic        i_boundary,
    input  wire logic        i_trap_exec,
    input  wire logic [1:0]  i_trap_num,
    input  wire logic        i_sleep_direct,
    input  wire logic        i_mask_set,
    input  wire logic        i_mask_clr,
    input  wire logic        i_ack,
    input  wire logic [7:0]  i_vec_byte,
    // Interrupt request levels, indexed by vector number
    input  wire logic [evpu_pkg::NUM_VEC-1:0] i_irq,
    // Sequencer outputs
    output logic             o_mask_bit,
    output logic             o_take,
    output logic [5:0]       o_vec_num,
    output logic [15:0]      o_vec_addr,
    output logic             o_pc_load,
    output logic [15:0]      o_pc,
    output logic             o_in_reset
);
    import evpu_pkg::*;

    evpu_state_e      state_q, state_d;
    logic             mask_q;
    logic [5:0]       vec_q;
    logic [15:0]      addr_q;
    logic [15:0]      pc_q;
    logic             pcld_q;
    logic             take_q;
    logic             wdt_q;
    logic [NUM_VEC-1:0] pend;
    logic             any;
    logic [5:0]       win;

    // Interrupt candidates; mask hides all but the non-maskable line
    assign pend = i_irq & VALID_MASK &
                  ~(MASKABLE & {NUM_VEC{mask_q}});

    evpu_prio_enc u_enc
    (
        .i_req (pend),
        .o_any (any),
        .o_vec (win)
    );

    // Trap and sleep are synchronous to the executing instruction
    wire        run       = (state_q == EVPU_RUN);
    wire        trap_go   = run && i_trap_exec;
    wire        sleep_go  = run && !i_trap_exec && i_sleep_direct;
    wire        irq_go    = run && i_boundary && any
                            && !i_trap_exec && !i_sleep_direct;
    wire        start     = trap_go || sleep_go || irq_go;
    wire [5:0]  sel_vec   = trap_go  ? (VEC_TRAP0 + {4'h0, i_trap_num})
                          : sleep_go ? VEC_SLEEP
                          : win;

    // Next state of the vector fetch sequence
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            EVPU_RESET:    state_d = EVPU_FETCH_HI;
            EVPU_FETCH_HI: if (i_ack) state_d = EVPU_FETCH_LO;
            EVPU_FETCH_LO: if (i_ack) state_d = (vec_q == VEC_RESET) ?
                                               EVPU_FIRST : EVPU_RUN;
            EVPU_FIRST:    if (i_boundary) state_d = EVPU_RUN;
            EVPU_RUN:      if (start) state_d = EVPU_FETCH_HI;
        endcase
    end

    // Sequencer registers; watchdog reset is a separate synchronous branch, one cycle late, that keeps pc_q
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= EVPU_RESET;
            mask_q  <= MASK_RESET;
            vec_q   <= VEC_RESET;
            addr_q  <= 16'h0000;
            pc_q    <= 16'h0000;
            pcld_q  <= 1'b0;
            take_q  <= 1'b0;
            wdt_q   <= 1'b0;
        end
        else if (wdt_q)
        begin
            state_q <= EVPU_RESET;
            mask_q  <= MASK_RESET;
            vec_q   <= VEC_RESET;
            addr_q  <= 16'h0000;
            pcld_q  <= 1'b0;
            take_q  <= 1'b0;
            wdt_q   <= 1'b0;
        end
        else
        begin
            wdt_q   <= i_wdt_reset_ovf;
            state_q <= state_d;
            pcld_q  <= (state_q == EVPU_FETCH_LO) && i_ack;
            take_q  <= start;
            if (start)
            begin
                vec_q  <= sel_vec;
                addr_q <= {9'h000, sel_vec, 1'b0};
                mask_q <= 1'b1;
            end
            else if (state_q == EVPU_RUN && i_mask_set)
                mask_q <= 1'b1;
            else if (state_q == EVPU_RUN && i_mask_clr)
                mask_q <= 1'b0;
            if (state_q == EVPU_FETCH_HI && i_ack)
            begin
                pc_q[15:8] <= i_vec_byte;
                addr_q     <= addr_q + 16'h0001;
            end
            if (state_q == EVPU_FETCH_LO && i_ack)
                pc_q[7:0] <= i_vec_byte;
        end
    end

    // Vector 34 and 35 merge upstream; shared lines need no extra logic
    assign o_mask_bit = mask_q;
    assign o_take     = take_q;
    assign o_vec_num  = vec_q;
    assign o_vec_addr = addr_q;
    assign o_pc_load  = pcld_q;
    assign o_pc       = pc_q;
    assign o_in_reset = (state_q == EVPU_RESET);

    // True when no legal request line outranks vector number v
    function automatic logic none_above(input logic [NUM_VEC-1:0] req,
                                        input logic [5:0]         v);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < NUM_VEC; k++)
            if (6'(k) < v && req[k] && VALID_MASK[k])
                hit = 1'b1;
        return !hit;
    endfunction : none_above

    // Assertions; a watchdog reset in the same cycle overrides any accept
    masked_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (irq_go && mask_q) |-> (win == VEC_NMI))
        else $error("maskable interrupt taken while masked");
    nmi_pass_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (run && i_boundary && i_irq[VEC_NMI] && !i_trap_exec
         && !i_sleep_direct && !wdt_q) |=> (take_q && vec_q == VEC_NMI))
        else $error("non-maskable request not taken");
    reserved_vec_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        take_q |-> (VALID_MASK[vec_q] || vec_q == VEC_SLEEP
                   || (vec_q >= VEC_TRAP0 && vec_q <= VEC_TRAP0 + 6'h03)))
        else $error("reserved vector generated");
    trap_vec_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (trap_go && !wdt_q)
        |=> (vec_q == VEC_TRAP0 + {4'h0, $past(i_trap_num)}))
        else $error("trap vector wrong");
    addr_twice_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        take_q |-> (o_vec_addr == (16'(vec_q) << 1)))
        else $error("vector address not twice number");
    boundary_only_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (run && !i_boundary && !i_trap_exec && !i_sleep_direct)
        |=> !take_q)
        else $error("interrupt taken off boundary");
    prio_first_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        irq_go |-> (pend[win] && none_above(pend, win)))
        else $error("lower priority request taken first");
    reset_first_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        $rose(state_q == EVPU_FETCH_HI && vec_q == VEC_RESET)
        |-> mask_q)
        else $error("mask not set at reset");
    after_reset_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (state_q == EVPU_FIRST) |=> !take_q)
        else $error("interrupt before first instruction");
    wdt_reset_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        wdt_q |=> (state_q == EVPU_RESET && vec_q == VEC_RESET))
        else $error("watchdog reset not taken");
    sleep_vec_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (sleep_go && !wdt_q) |=> (vec_q == VEC_SLEEP))
        else $error("sleep vector wrong");
    ivl_vec_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (irq_go && !wdt_q && !mask_q && i_irq[VEC_WDT]
         && none_above(i_irq, VEC_WDT)) |=> (vec_q == VEC_WDT))
        else $error("watchdog interval vector wrong");
    event_vec_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (irq_go && !wdt_q && !mask_q && i_irq[VEC_AEC]
         && none_above(i_irq, VEC_AEC)) |=> (vec_q == VEC_AEC))
        else $error("event counter vector wrong");
    timer_vec_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (irq_go && !wdt_q && !mask_q && i_irq[VEC_TIMW]
         && none_above(i_irq, VEC_TIMW)) |=> (vec_q == VEC_TIMW))
        else $error("shared timer vector wrong");
    serial_vec_a: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (irq_go && !wdt_q && !mask_q && i_irq[VEC_SERIAL]
         && none_above(i_irq, VEC_SERIAL)) |=> (vec_q == VEC_SERIAL))
        else $error("shared serial vector wrong");
endmodule : evpu_top

// ===== bench/evpu_mem_model.sv
// Vector memory model answering the unit's two-byte fetches
`timescale 1ns/1ps
module evpu_mem_model
(
    // Clock and controls
    input  wire logic        i_clk,
    input  wire logic        i_slow,
    // Unit outputs
    input  wire logic        i_take,
    input  wire logic        i_in_reset,
    input  wire logic [15:0] i_addr,
    // Answer
    output logic             o_ack,
    output logic [7:0]       o_byte
);
    logic prev_q;
    // Fetch starts on accept or on leaving reset; bus shows junk when idle
    initial
    begin
        o_ack  = 1'b0;
        o_byte = 8'h00;
        prev_q = 1'b1;
        forever
        begin
            @(posedge i_clk);
            if (i_take || (prev_q && !i_in_reset))
            begin
                repeat (i_slow ? 3 : 0) @(posedge i_clk);
                repeat (2)
                begin
                    #1 o_ack = 1'b1;
                    o_byte = i_addr[7:0] + 8'h30;
                    @(posedge i_clk);
                end
                #1 o_ack = 1'b0;
                o_byte = ~o_byte;
            end
            prev_q = i_in_reset;
        end
    end
endmodule : evpu_mem_model

// ===== bench/evpu_top_tb_top.sv
// Self-checking bench for the exception vector and priority unit
`timescale 1ns/1ps
module evpu_top_tb_top;
    import evpu_pkg::*;
    logic        clk, nrst, wdt, bnd, trap, sleep, mset, mclr, slow;
    logic [1:0]  tnum;
    logic [39:0] irq;
    logic        ack, mask, take, pcl, inrst;
    logic [7:0]  vbyte;
    logic [5:0]  vnum;
    logic [15:0] vaddr, pc;
    int          err_count = 0;
    int          checks = 0;
    int          cyc = 0;
    evpu_top dut (.i_clk(clk), .i_nrst(nrst), .i_wdt_reset_ovf(wdt),
        .i_boundary(bnd), .i_trap_exec(trap), .i_trap_num(tnum),
        .i_sleep_direct(sleep), .i_mask_set(mset), .i_mask_clr(mclr),
        .i_ack(ack), .i_vec_byte(vbyte), .i_irq(irq), .o_mask_bit(mask),
        .o_take(take), .o_vec_num(vnum), .o_vec_addr(vaddr),
        .o_pc_load(pcl), .o_pc(pc), .o_in_reset(inrst));
    evpu_mem_model mem (.i_clk(clk), .i_slow(slow), .i_take(take),
        .i_in_reset(inrst), .i_addr(vaddr), .o_ack(ack), .o_byte(vbyte));
    // 25 MHz clock; a hang is cut short well past the expected run
    initial clk = 1'b0;
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            complete_run();
        end
    end
    task automatic complete_run;
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic pulse(ref logic s);
        tick(1);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    // Wait for accept and fetch, then judge vector number, address and PC
    task automatic exc(input logic [5:0] v, input logic rst);
        int         n;
        logic [7:0] b;
        n = 0;
        b = {1'b0, v, 1'b0} + 8'h30;
        while (!rst && take !== 1'b1 && n < 30)
        begin
            tick(1);
            n++;
        end
        if (!rst)
        begin
            check(take, 1'b1);
            check(vaddr, {9'h000, v, 1'b0});
        end
        while (pcl !== 1'b1 && n < 60)
        begin
            tick(1);
            n++;
        end
        check(pcl, 1'b1);
        check(vnum, v);
        check(pc, {b, b + 8'h01});
        check(mask, 1'b1);
    endtask : exc
    task automatic s_first;
        irq[7] = 1'b1;
        bnd = 1'b1;
        tick(1);
        check(take, 1'b0);
        exc(VEC_NMI, 1'b0);
        irq[7] = 1'b0;
        bnd = 1'b0;
    endtask : s_first
    // Traps and sleep with the mask set, slow memory answers
    task automatic s_trap;
        slow = 1'b1;
        for (int n = 0; n < 4; n++)
        begin
            tnum = n[1:0];
            pulse(trap);
            exc(VEC_TRAP0 + 6'(n), 1'b0);
        end
        pulse(sleep);
        exc(VEC_SLEEP, 1'b0);
        slow = 1'b0;
    endtask : s_trap
    task automatic s_mask;
        irq[16] = 1'b1;
        pulse(mclr);
        check(mask, 1'b0);
        pulse(mset);
        check(mask, 1'b1);
        bnd = 1'b1;
        tick(4);
        check(vnum, VEC_SLEEP);
        bnd = 1'b0;
        pulse(mclr);
        tick(3);
        check(vnum, VEC_SLEEP);
        bnd = 1'b1;
        exc(6'd16, 1'b0);
        irq[16] = 1'b0;
        bnd = 1'b0;
    endtask : s_mask
    // Pending 31, 32, 34, 35 plus reserved lines 12, 36, 39
    task automatic s_prio;
        logic [5:0] v[4] = '{6'd31, 6'd32, 6'd34, 6'd35};
        irq = 40'h9D_8000_1000;
        foreach (v[i])
        begin
            pulse(mclr);
            bnd = 1'b1;
            exc(v[i], 1'b0);
            irq[v[i]] = 1'b0;
            bnd = 1'b0;
        end
        pulse(mclr);
        bnd = 1'b1;
        tick(6);
        check(vnum, VEC_TIMW);
        bnd = 1'b0;
        irq = '0;
    endtask : s_prio
    task automatic s_wdt;
        pulse(wdt);
        tick(1);
        check(inrst, 1'b1);
        exc(VEC_RESET, 1'b1);
    endtask : s_wdt
    // Pin reset in mid-run with the mask cleared, then a fresh fetch
    task automatic s_pin;
        bnd = 1'b1;
        tick(1);
        bnd = 1'b0;
        pulse(mclr);
        check(mask, 1'b0);
        nrst = 1'b0;
        tick(2);
        check(inrst, 1'b1);
        check(pcl, 1'b0);
        check(mask, 1'b1);
        nrst = 1'b1;
        exc(VEC_RESET, 1'b1);
    endtask : s_pin
    initial
    begin
        {nrst, wdt, bnd, trap, sleep, mset, mclr, slow, tnum} = '0;
        irq = '0;
        tick(12);
        check(inrst, 1'b1);
        check(pcl, 1'b0);
        check(mask, 1'b1);
        nrst = 1'b1;
        exc(VEC_RESET, 1'b1);
        s_first();
        s_trap();
        s_mask();
        s_prio();
        s_wdt();
        s_pin();
        complete_run();
    end
endmodule : evpu_top_tb_top
